// ===== rtl/rcrx_defs.svh
// constants for the remote-control receive data path
`ifndef RCRX_DEFS_SVH
`define RCRX_DEFS_SVH
`define RCRX_ZERO8 8'h00
`define RCRX_BITS_PER_BYTE 8'h08
`define RCRX_LAST_BIT 8'h07
`define RCRX_MSB 7
`define RCRX_CNT_ONE 8'h01
`define RCRX_CNT_MAX 8'hFF
`define RCRX_FIFO_DEPTH 16
`define RCRX_FIFO_WIDTH 8
`define RCRX_END_SCALE 8'h10
`endif

// ===== rtl/rcrx_pkg.sv
// types for the remote-control receive data path
package rcrx_pkg;
    // compare settings from software
    typedef struct packed {
        logic [7:0] guide_high_min;
        logic [7:0] guide_high_max;
        logic [7:0] guide_low_min;
        logic [7:0] guide_low_max;
        logic [7:0] data_low_min;
        logic [7:0] data_low_max;
        logic [7:0] zero_high_min;
        logic [7:0] zero_high_max;
        logic [7:0] one_high_min;
        logic [7:0] one_high_max;
        logic [7:0] end_width_select;
    } rcrx_cfg_t;
    // event strobes
    typedef struct packed {
        logic rx_error_event;
        logic data_full_event;
        logic rx_end_event;
    } rcrx_evt_t;
    typedef enum logic [4:0] {
        RCRX_IDLE = 5'b0_0001,
        RCRX_GLOW = 5'b0_0010,
        RCRX_GHIGH = 5'b0_0100,
        RCRX_DLOW = 5'b0_1000,
        RCRX_DHIGH = 5'b1_0000
    } rcrx_state_t;
endpackage : rcrx_pkg

// ===== rtl/rcrx_top.sv
// remote-control receive data path with byte fifo
`timescale 1ns/10ps
`default_nettype none
`include "rcrx_defs.svh"

// Notes on behaviour
// [RULE1] only type A frames with guide pulse
// [RULE2] new bit enters bit 7, shifts down
// [RULE3] shift register clears on reset, disable, error, full, read
// [RULE4] software reads shift register only after end
// [RULE5] full byte copied to holding register, cleared
// [RULE6] data-full event same cycle as copy
// [RULE7] holding register overwritten by next byte
// [RULE8] bit counter counts bits, wraps 07H to 00H
// [RULE9] bit counter clears on reset, disable, error, read
// [RULE10] software reads counter first after end event
// [RULE11] guide high valid when min <= width < max
// [RULE12] guide high settings 8-bit, writable, reset 00H
// [RULE13] zero bit when zero-high window matches
// [RULE14] one bit when one-high window matches
// [RULE15] software disables before changing settings
// [RULE16] width counter restarts at each input edge
// [RULE17] out-of-window width errors, back to idle

// ********************************************************
// byte fifo
// ********************************************************
module rcrx_fifo #(
    parameter int WIDTH = `RCRX_FIFO_WIDTH,
    parameter int DEPTH = `RCRX_FIFO_DEPTH
) (
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic i_flush,
    input wire logic i_in_valid,
    output logic o_in_ready,
    input wire logic [WIDTH-1:0] i_in_data,
    output logic o_out_valid,
    input wire logic i_out_ready,
    output logic [WIDTH-1:0] o_out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wp_r;
    logic [AW-1:0] rp_r;
    logic [AW:0] cnt_r;
    logic push;
    logic pop;
    assign o_in_ready = (cnt_r != (AW+1)'(DEPTH));
    assign o_out_valid = (cnt_r != '0);
    assign o_out_data = mem[rp_r];
    assign push = i_in_valid && o_in_ready;
    assign pop = o_out_valid && i_out_ready;
    always_ff @(posedge i_clk) begin
        if (push) begin
            mem[wp_r] <= i_in_data;
        end
    end
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
        end else if (i_flush) begin
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
        end else begin
            if (push) begin
                wp_r <= (wp_r == AW'(DEPTH-1)) ? '0 : wp_r + 1'b1;
            end
            if (pop) begin
                rp_r <= (rp_r == AW'(DEPTH-1)) ? '0 : rp_r + 1'b1;
            end
            cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule : rcrx_fifo

// ********************************************************
// receiver top
// ********************************************************
module rcrx_top (
    input wire logic I_CLK,
    input wire logic I_RSTN,
    input wire logic I_RX_PIN,
    input wire logic I_RECEPTION_ENABLE,
    input wire logic I_INPUT_INVERT,
    input wire rcrx_pkg::rcrx_cfg_t I_CFG,
    input wire logic I_SHIFT_RD,
    input wire logic I_FIFO_RD,
    output logic [7:0] O_RX_SHIFT_REG,
    output logic [7:0] O_RX_DATA_HOLD,
    output logic [7:0] O_RX_BIT_COUNT,
    output logic O_FIFO_VALID,
    output logic [7:0] O_FIFO_DATA,
    output logic O_FIFO_OVERRUN,
    output rcrx_pkg::rcrx_evt_t O_EVT
);
    import rcrx_pkg::*;

    // ****************************************************
    // input synchroniser and edge detect
    // ****************************************************
    logic sync1_r;
    logic sync2_r;
    logic lvl_r;
    logic edge_w;
    logic lvl_w;
    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            sync1_r <= 1'b0;
            sync2_r <= 1'b0;
            lvl_r <= 1'b0;
        end else begin
            sync1_r <= I_RX_PIN;
            sync2_r <= sync1_r;
            lvl_r <= lvl_w;
        end
    end
    assign lvl_w = sync2_r ^ I_INPUT_INVERT;
    assign edge_w = I_RECEPTION_ENABLE && (lvl_w != lvl_r);

    function automatic logic in_win(input logic [7:0] v,
                                    input logic [7:0] lo,
                                    input logic [7:0] hi);
        in_win = (v >= lo) && (v < hi);
    endfunction : in_win

    // ****************************************************
    // width counter
    // ****************************************************
    logic [7:0] width_r;
    logic [11:0] end_cnt_r;
    logic end_hit;
    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            width_r <= `RCRX_ZERO8;
        end else if (!I_RECEPTION_ENABLE || edge_w) begin
            width_r <= `RCRX_ZERO8; // see [RULE16]
        end else if (width_r != `RCRX_CNT_MAX) begin
            // saturates so a long level stays outside every window
            width_r <= width_r + `RCRX_CNT_ONE; // see [RULE16]
        end
    end
    // low level after last bit lasting end_width_select*16 ends frame
    assign end_hit = (end_cnt_r == {I_CFG.end_width_select, 4'h0})
                     && (I_CFG.end_width_select != `RCRX_ZERO8);

    // ****************************************************
    // frame state machine
    // ****************************************************
    rcrx_state_t state_r;
    rcrx_state_t state_nxt;
    logic bit_ok;
    logic bit_val;
    logic err_w;
    logic end_w;
    logic ended_r;
    always_comb begin
        state_nxt = state_r;
        bit_ok = 1'b0;
        bit_val = 1'b0;
        err_w = 1'b0;
        end_w = 1'b0;
        case (state_r)
            RCRX_IDLE: begin
                if (edge_w && lvl_w) begin
                    state_nxt = RCRX_GHIGH; // see [RULE1]
                end
            end
            RCRX_GHIGH: begin
                if (edge_w) begin
                    if (in_win(width_r, I_CFG.guide_high_min, // see [RULE12]
                               I_CFG.guide_high_max)) begin
                        state_nxt = RCRX_GLOW; // see [RULE11]
                    end else begin
                        err_w = 1'b1; // see [RULE17]
                        state_nxt = RCRX_IDLE;
                    end
                end
            end
            RCRX_GLOW: begin
                if (edge_w) begin
                    if (in_win(width_r, I_CFG.guide_low_min,
                               I_CFG.guide_low_max)) begin
                        state_nxt = RCRX_DHIGH;
                    end else begin
                        err_w = 1'b1; // see [RULE17]
                        state_nxt = RCRX_IDLE;
                    end
                end
            end
            RCRX_DHIGH: begin
                if (edge_w) begin
                    if (in_win(width_r, I_CFG.zero_high_min,
                               I_CFG.zero_high_max)) begin
                        bit_ok = 1'b1; // see [RULE13]
                        state_nxt = RCRX_DLOW;
                    end else if (in_win(width_r, I_CFG.one_high_min,
                                        I_CFG.one_high_max)) begin
                        bit_ok = 1'b1; // see [RULE14]
                        bit_val = 1'b1;
                        state_nxt = RCRX_DLOW;
                    end else begin
                        err_w = 1'b1; // see [RULE17]
                        state_nxt = RCRX_IDLE;
                    end
                end
            end
            RCRX_DLOW: begin
                if (end_hit) begin
                    end_w = 1'b1;
                    state_nxt = RCRX_IDLE;
                end else if (edge_w) begin
                    if (in_win(width_r, I_CFG.data_low_min,
                               I_CFG.data_low_max)) begin
                        state_nxt = RCRX_DHIGH;
                    end else begin
                        err_w = 1'b1; // see [RULE17]
                        state_nxt = RCRX_IDLE;
                    end
                end
            end
            default: begin
                state_nxt = RCRX_IDLE;
            end
        endcase
    end
    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            state_r <= RCRX_IDLE;
        end else if (!I_RECEPTION_ENABLE) begin
            state_r <= RCRX_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end
    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            end_cnt_r <= 12'h000;
        end else if (state_r != RCRX_DLOW || edge_w) begin
            end_cnt_r <= 12'h000;
        end else if (end_cnt_r != 12'hFFF) begin
            end_cnt_r <= end_cnt_r + 12'h001;
        end
    end

    // ****************************************************
    // shift register, bit counter, holding register
    // ****************************************************
    logic [7:0] shift_nxt;
    logic full_w;
    logic rd_clear;
    assign shift_nxt = {bit_val, O_RX_SHIFT_REG[`RCRX_MSB:1]}; // see [RULE2]
    assign full_w = bit_ok && (O_RX_BIT_COUNT == `RCRX_LAST_BIT);
    // read after end clears; software keeps ordering, see [RULE4] [RULE10]
    assign rd_clear = I_SHIFT_RD && ended_r;
    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            ended_r <= 1'b0;
        end else if (!I_RECEPTION_ENABLE || err_w) begin
            ended_r <= 1'b0;
        end else if (end_w) begin
            // a new end outranks a read in the same cycle
            ended_r <= 1'b1;
        end else if (rd_clear) begin
            ended_r <= 1'b0;
        end
    end
    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            O_RX_SHIFT_REG <= `RCRX_ZERO8;
        end else if (!I_RECEPTION_ENABLE || err_w || full_w
                     || rd_clear) begin
            O_RX_SHIFT_REG <= `RCRX_ZERO8; // see [RULE3] [RULE5]
        end else if (bit_ok) begin
            O_RX_SHIFT_REG <= shift_nxt; // see [RULE2]
        end
    end
    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            O_RX_BIT_COUNT <= `RCRX_ZERO8;
        end else if (!I_RECEPTION_ENABLE || err_w || rd_clear
                     || full_w) begin
            O_RX_BIT_COUNT <= `RCRX_ZERO8; // see [RULE9] [RULE8]
        end else if (bit_ok) begin
            O_RX_BIT_COUNT <= O_RX_BIT_COUNT + `RCRX_CNT_ONE; // see [RULE8]
        end
    end
    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            O_RX_DATA_HOLD <= `RCRX_ZERO8;
        end else if (full_w) begin
            O_RX_DATA_HOLD <= shift_nxt; // see [RULE5] [RULE7]
        end
    end
    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            O_EVT <= '0;
        end else begin
            O_EVT.rx_error_event <= err_w;
            O_EVT.data_full_event <= full_w; // see [RULE6]
            O_EVT.rx_end_event <= end_w;
        end
    end

    // ****************************************************
    // byte fifo loaded alongside the holding register
    // ****************************************************
    logic fifo_ready;
    logic fifo_valid;
    logic [7:0] fifo_data;
    rcrx_fifo #(.WIDTH(`RCRX_FIFO_WIDTH), .DEPTH(`RCRX_FIFO_DEPTH)) u_fifo (
        .i_clk(I_CLK),
        .i_rstn(I_RSTN),
        .i_flush(!I_RECEPTION_ENABLE),
        .i_in_valid(full_w),
        .o_in_ready(fifo_ready),
        .i_in_data(shift_nxt),
        .o_out_valid(fifo_valid),
        .i_out_ready(I_FIFO_RD && O_FIFO_VALID),
        .o_out_data(fifo_data)
    );
    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            O_FIFO_VALID <= 1'b0;
            O_FIFO_DATA <= `RCRX_ZERO8;
            O_FIFO_OVERRUN <= 1'b0;
        end else begin
            O_FIFO_VALID <= fifo_valid && !(I_FIFO_RD && O_FIFO_VALID);
            O_FIFO_DATA <= fifo_data;
            if (!I_RECEPTION_ENABLE) begin
                O_FIFO_OVERRUN <= 1'b0;
            end else if (full_w && !fifo_ready) begin
                O_FIFO_OVERRUN <= 1'b1;
            end
        end
    end
endmodule : rcrx_top
`default_nettype wire

// ===== testbench/rcrx_assertions.sv
// assertion checker for the remote-control receive data path
`timescale 1ns/10ps
`default_nettype none
module rcrx_assertions (
    input wire logic I_CLK,
    input wire logic I_RSTN,
    input wire logic I_RECEPTION_ENABLE,
    input wire logic I_SHIFT_RD,
    input wire logic [7:0] O_RX_SHIFT_REG,
    input wire logic [7:0] O_RX_DATA_HOLD,
    input wire logic [7:0] O_RX_BIT_COUNT,
    input wire rcrx_pkg::rcrx_evt_t O_EVT
);
    import rcrx_pkg::*;
    // ********************************************************
    // properties
    // ********************************************************
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (!I_RSTN);
    logic clr;
    assign clr = (O_RX_SHIFT_REG == 8'h00) && (O_RX_BIT_COUNT == 8'h00);
    sequence s_bit;
        $changed(O_RX_BIT_COUNT) && (O_RX_BIT_COUNT != 8'h00);
    endsequence
    sequence s_end_read;
        O_EVT.rx_end_event ##[1:40] I_SHIFT_RD;
    endsequence
    sequence s_off;
        !I_RECEPTION_ENABLE [*2];
    endsequence
    property p_shift_in;
        s_bit |-> ({1'h0, O_RX_SHIFT_REG[6:0]} ==
            ($past(O_RX_SHIFT_REG) >> 1));
    endproperty
    a_shift_in: assert property (p_shift_in)
        else $error("shift register did not move down");
    property p_count_step;
        s_bit |-> O_RX_BIT_COUNT == $past(O_RX_BIT_COUNT) + 8'h01;
    endproperty
    a_count_step: assert property (p_count_step)
        else $error("bit count did not step by one");
    property p_count_max;
        O_RX_BIT_COUNT <= 8'h07;
    endproperty
    a_count_max: assert property (p_count_max)
        else $error("bit count above seven");
    property p_full_copy;
        O_EVT.data_full_event |-> ($past(O_RX_BIT_COUNT) == 8'h07) &&
            ({1'h0, O_RX_DATA_HOLD[6:0]} == ($past(O_RX_SHIFT_REG) >> 1));
    endproperty
    a_full_copy: assert property (p_full_copy)
        else $error("holding register not loaded from shift");
    property p_full_clear;
        O_EVT.data_full_event |-> clr;
    endproperty
    a_full_clear: assert property (p_full_clear)
        else $error("shift not cleared on full");
    property p_hold_cause;
        $changed(O_RX_DATA_HOLD) |-> O_EVT.data_full_event;
    endproperty
    a_hold_cause: assert property (p_hold_cause)
        else $error("holding register changed without full event");
    property p_err_clear;
        O_EVT.rx_error_event |-> clr;
    endproperty
    a_err_clear: assert property (p_err_clear)
        else $error("error did not clear shift and count");
    property p_off_clear;
        s_off |-> clr;
    endproperty
    a_off_clear: assert property (p_off_clear)
        else $error("disable did not clear shift and count");
    property p_end_read;
        s_end_read |=> clr;
    endproperty
    a_end_read: assert property (p_end_read)
        else $error("read after end did not clear");
endmodule : rcrx_assertions
bind rcrx_top rcrx_assertions u_chk (.I_CLK(I_CLK), .I_RSTN(I_RSTN),
    .I_RECEPTION_ENABLE(I_RECEPTION_ENABLE), .I_SHIFT_RD(I_SHIFT_RD),
    .O_RX_SHIFT_REG(O_RX_SHIFT_REG), .O_RX_DATA_HOLD(O_RX_DATA_HOLD),
    .O_RX_BIT_COUNT(O_RX_BIT_COUNT), .O_EVT(O_EVT));
`default_nettype wire

// ===== testbench/rcrx_ir_src.sv
// infrared remote source model driving the receive pin
`timescale 1ns/10ps
`default_nettype none
module rcrx_ir_src (
    input wire logic i_clk,
    input wire logic i_inv,
    output logic o_pin
);
    // ********************************************************
    // pulse generation, idle level low, inverted on the wire when i_inv is set
    // ********************************************************
    logic lvl_r = 1'h0;
    assign o_pin = lvl_r ^ i_inv;
    task automatic lvl(input logic v, input int n);
        @(posedge i_clk);
        lvl_r <= v;
        repeat (n - 1) @(posedge i_clk);
    endtask : lvl
    task automatic guide(input int h);
        lvl(1'h1, h);
        lvl(1'h0, 30);
    endtask : guide
    // first bit goes out first, high width encodes the value
    task automatic send(input logic [7:0] d, input int n);
        for (int i = 0; i < n; i++) begin
            lvl(1'h1, d[i] ? 25 : 10);
            lvl(1'h0, 10);
        end
    endtask : send
endmodule : rcrx_ir_src
`default_nettype wire

// ===== testbench/rcrx_top_tb.sv
// self-checking testbench for the remote-control receive data path
`timescale 1ns/10ps
`default_nettype none
module rcrx_top_tb;
    import rcrx_pkg::*;
    logic clk = 1'h0, rstn = 1'h0, en = 1'h0, shrd = 1'h0, frd = 1'h0;
    logic inv = 1'h0;
    logic pin, fval, fovr;
    logic [7:0] sh, hold, cnt, fdat;
    logic [7:0] n_err = 8'h00, n_end = 8'h00, n_full = 8'h00;
    rcrx_cfg_t cfg = '0;
    rcrx_evt_t evt;
    int failures = 0, comparisons = 0;
    always #5 clk = ~clk;
    always @(posedge clk) begin
        n_err <= n_err + {7'h00, evt.rx_error_event};
        n_end <= n_end + {7'h00, evt.rx_end_event};
        n_full <= n_full + {7'h00, evt.data_full_event};
    end
    rcrx_ir_src u_ir (.i_clk(clk), .i_inv(inv), .o_pin(pin));
    rcrx_top u_dut (.I_CLK(clk), .I_RSTN(rstn), .I_RX_PIN(pin),
        .I_RECEPTION_ENABLE(en), .I_INPUT_INVERT(inv), .I_CFG(cfg),
        .I_SHIFT_RD(shrd), .I_FIFO_RD(frd), .O_RX_SHIFT_REG(sh),
        .O_RX_DATA_HOLD(hold), .O_RX_BIT_COUNT(cnt), .O_FIFO_VALID(fval),
        .O_FIFO_DATA(fdat), .O_FIFO_OVERRUN(fovr), .O_EVT(evt));
    // ********************************************************
    // tasks
    // ********************************************************
    task automatic test_done;
        $display("failures=%0d comparisons=%0d", failures, comparisons);
        if (failures == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : test_done
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic rd(input logic fifo);
        @(posedge clk);
        frd <= fifo;
        shrd <= !fifo;
        @(posedge clk);
        frd <= 1'h0;
        shrd <= 1'h0;
        // fifo outputs settle one cycle after the pop
        @(posedge clk);
        @(negedge clk);
    endtask : rd
    task automatic pop(input logic [7:0] exp);
        chk({7'h00, fval}, 8'h01);
        chk(fdat, exp);
        rd(1'h1);
    endtask : pop
    task automatic set_en(input logic v);
        @(posedge clk);
        en <= v;
    endtask : set_en
    initial begin
        repeat (100000) @(posedge clk);
        failures++;
        test_done();
    end
    // ********************************************************
    // scenarios
    // ********************************************************
    initial begin
        repeat (4) @(posedge clk);
        rstn <= 1'h1;
        @(negedge clk);
        chk(sh, 8'h00);
        chk(hold, 8'h00);
        chk(cnt, 8'h00);
        set_en(1'h1);
        u_ir.guide(50);
        @(negedge clk);
        chk(n_err, 8'h01);
        set_en(1'h0);
        cfg <= '{8'h28, 8'h3C, 8'h14, 8'h28, 8'h05, 8'h0F, 8'h05, 8'h0F,
            8'h14, 8'h1E, 8'h04};
        set_en(1'h1);
        u_ir.guide(50);
        u_ir.send(8'h55, 8);
        @(negedge clk);
        chk(hold, 8'h55);
        chk(n_full, 8'h01);
        u_ir.send(8'h03, 2);
        u_ir.lvl(1'h0, 70);
        @(negedge clk);
        chk(n_end, 8'h01);
        chk(cnt, 8'h02);
        chk(sh, 8'hC0);
        rd(1'h0);
        chk(sh, 8'h00);
        chk(cnt, 8'h00);
        u_ir.guide(50);
        u_ir.send(8'hFF, 8);
        u_ir.lvl(1'h0, 70);
        @(negedge clk);
        chk(hold, 8'hFF);
        pop(8'h55);
        u_ir.guide(70);
        u_ir.guide(30);
        @(negedge clk);
        chk(n_err, 8'h03);
        u_ir.guide(50);
        u_ir.send(8'h07, 3);
        @(negedge clk);
        chk(sh, 8'hE0);
        chk(cnt, 8'h03);
        u_ir.lvl(1'h1, 40);
        u_ir.lvl(1'h0, 10);
        @(negedge clk);
        chk(n_err, 8'h04);
        chk(sh, 8'h00);
        u_ir.guide(50);
        u_ir.send(8'h00, 1);
        set_en(1'h0);
        repeat (3) @(negedge clk);
        chk(cnt, 8'h00);
        chk({7'h00, fval}, 8'h00);
        set_en(1'h1);
        u_ir.guide(50);
        for (int i = 0; i < 17; i++) u_ir.send(i[7:0], 8);
        u_ir.lvl(1'h0, 70);
        @(negedge clk);
        chk(hold, 8'h10);
        chk({7'h00, fovr}, 8'h01);
        for (int i = 0; i < 16; i++) pop(i[7:0]);
        chk({7'h00, fval}, 8'h00);
        // inverted input: pin idles high, pulses low
        set_en(1'h0);
        inv <= 1'h1;
        u_ir.lvl(1'h0, 4);
        set_en(1'h1);
        u_ir.guide(50);
        u_ir.send(8'hA5, 8);
        @(negedge clk);
        chk(hold, 8'hA5);
        chk(n_full, 8'h14);
        chk(n_err, 8'h04);
        chk({7'h00, fovr}, 8'h00);
        pop(8'hA5);
        test_done();
    end
endmodule : rcrx_top_tb
`default_nettype wire
